// ### src/acso_regs.svh
`ifndef ACSO_REGS_SVH
`define ACSO_REGS_SVH

// Register indices; byte address is four times the index
`define ACSO_IDX_PWR         8'h08
`define ACSO_IDX_DCS         8'h09
`define ACSO_IDX_DIV         8'h0b
`define ACSO_IDX_STAT        8'h10
`define ACSO_IDX_FMT         8'h14
`define ACSO_IDX_SYNC        8'h3a

// Field positions
`define ACSO_SYNC_EN_BIT     0
`define ACSO_SYNC_EVERY_BIT  1
`define ACSO_DCS_EN_BIT      0
`define ACSO_FMT_TWOS_BIT    0
`define ACSO_STAT_SEEN_BIT   3
`define ACSO_STAT_LOCK_BIT   4
`define ACSO_STAT_PWR_LSB    5

// Power mode codes held in the power register
`define ACSO_PM_NORMAL       2'h0
`define ACSO_PM_DOWN         2'h1
`define ACSO_PM_STANDBY      2'h2

// Reset values
`define ACSO_RST_DIV_M1      3'h0
`define ACSO_RST_DCS_EN      1'b1
`define ACSO_RST_PM          2'h0
`define ACSO_RST_TWOS        1'b0
`define ACSO_RST_SYNC        2'h0

// Timing and sizes
`define ACSO_CLK_PERIOD_NS   100
`define ACSO_DCS_RELOCK_NS   5000
`define ACSO_DCS_RELOCK_CYC  (`ACSO_DCS_RELOCK_NS / `ACSO_CLK_PERIOD_NS)
`define ACSO_STBY_WAKE_NS    1000
`define ACSO_STBY_WAKE_CYC   (`ACSO_STBY_WAKE_NS / `ACSO_CLK_PERIOD_NS)
`define ACSO_DCS_MIN_HZ      40000000
`define ACSO_LATENCY         9
`define ACSO_WAKE_SHIFT      4

`endif

// ### src/acso_pkg.sv
package acso_pkg;

   // Power sequencing states
   typedef enum logic [1:0] {PWR_RUN, PWR_STANDBY, PWR_DOWN, PWR_WAKE}
      acso_pwr_t;

   // Output frame phases, one input clock each
   typedef enum logic [1:0] {DDR_AC, DDR_RISE, DDR_BD, DDR_FALL} acso_ddr_t;

   typedef logic [15:0]        acso_word_t;
   typedef logic signed [17:0] acso_raw_t;

endpackage

// ### src/acso_div_if.sv
`timescale 1ns/1ps
`default_nettype none

// Link between the control logic and the clock divider
interface acso_div_if;
   logic       ce;        // Global clock enable
   logic       run;       // Divider clock running
   logic       resync;    // Return to initial state
   logic [2:0] ratio_m1;  // Division ratio minus one
   logic       tick;      // Internal sample clock edge
   logic [2:0] phase;     // Current input-cycle count

   modport ctrl (output ce, run, resync, ratio_m1, input tick, phase);
   modport div  (input ce, run, resync, ratio_m1, output tick, phase);
endinterface

`default_nettype wire

// ### src/acso_divider.sv
`timescale 1ns/1ps
`default_nettype none

module acso_divider
(
   input wire logic clock_i,    // Sample clock
   input wire logic sys_rst_i,  // Synchronous reset, active high
   acso_div_if.div  dv          // Control side
);

   logic [2:0] count_reg;
   logic [2:0] count_next;

   // Count input rising edges, wrap at the ratio
   always_comb
   begin
      count_next = count_reg;
      if (dv.resync)
         count_next = 3'h0;
      else if (dv.run)
         count_next = (count_reg >= dv.ratio_m1) ? 3'h0 : count_reg + 3'h1;
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         count_reg <= 3'h0;
      else if (dv.ce)
         count_reg <= count_next;
   end

   // One tick per ratio input cycles, at count zero
   assign dv.tick  = dv.run & ~dv.resync & (count_reg == 3'h0);
   assign dv.phase = count_reg;

endmodule

`default_nettype wire

// ### src/acso_top.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acso_regs.svh"

module acso_top
   import acso_pkg::*;
#(
   parameter int CLK_HZ  = 10000000,       // Input clock rate
   parameter int LATENCY = `ACSO_LATENCY,  // Sample clocks to output
   parameter int DOWN_W  = 16              // Power-down timer width
)
(
   input  wire logic        clock_i,           // Sample clock
   input  wire logic        sys_rst_i,         // Sync reset, high
   input  wire logic        ce_i,              // Clock enable
   input  wire logic        psel_i,            // APB select
   input  wire logic        penable_i,         // APB enable
   input  wire logic        pwrite_i,          // APB write
   input  wire logic [11:0] paddr_i,           // APB byte address
   input  wire logic [31:0] pwdata_i,          // APB write data
   output logic      [31:0] prdata_o,          // APB read data
   output logic             pready_o,          // APB ready
   output logic             pslverr_o,         // APB error
   input  wire logic        power_down_pin_i,  // Power-down pin
   input  wire logic        sync_i,            // Sync strobe pin
   input  wire logic [71:0] core_i,            // Raw A..D, 18b each
   output logic      [15:0] dlane0_o,          // A then B
   output logic      [15:0] dlane1_o,          // C then D
   output logic             data_clock_out_o,  // Data clock
   output logic             out_oe_n_o,        // Low: lanes driven
   output logic             int_clk_o,         // Internal clock
   output logic             sample_tick_o,     // Sample taken
   output logic             ref_en_o,          // Reference on
   output logic             bias_en_o,         // Bias on
   output logic             clk_run_o,         // Clock tree on
   output logic             dcs_locked_o       // Stabilizer locked
);

   // True when an aligned address hits a register index
   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      hit = (a[11:2] == {2'b00, idx}) & (a[1:0] == 2'b00);
   endfunction

   // Saturate to 16 bits, offset binary
   function automatic acso_word_t clamp_ob(input acso_raw_t raw);
      if (raw < -18'sd32768)
         clamp_ob = 16'h0000;
      else if (raw > 18'sd32767)
         clamp_ob = 16'hffff;
      else
         clamp_ob = {~raw[15], raw[14:0]};
   endfunction

   // Apply the selected output coding
   function automatic acso_word_t fmt(input acso_word_t ob, input logic twos);
      fmt = twos ? {~ob[15], ob[14:0]} : ob;
   endfunction

   // Stabilizer only works at or above its minimum rate
   function automatic logic dcs_capable(input logic [2:0] m1);
      dcs_capable = (CLK_HZ / (int'(m1) + 1)) >= `ACSO_DCS_MIN_HZ;
   endfunction

   acso_div_if dv ();

   acso_divider u_div (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .dv        (dv)
   );

   // Register file and bus state
   logic [2:0]  div_m1_reg, div_m1_next;
   logic        dcs_en_reg, dcs_en_next;
   logic [1:0]  pm_reg, pm_next;
   logic        twos_reg, twos_next;
   logic        sync_en_reg, sync_en_next;
   logic        sync_every_reg, sync_every_next;
   logic        sync_seen_reg, sync_seen_next;
   logic        sync_done_reg, sync_done_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        wr_acc;
   logic        sync_valid;
   logic [1:0]  pwr_bits;
   acso_pwr_t   pwr_reg;

   assign pwr_bits = pwr_reg;

   // Bus decode; answers one cycle after setup
   always_comb
   begin
      wr_acc          = psel_i & penable_i & pwrite_i & pready_reg;
      div_m1_next     = div_m1_reg;
      dcs_en_next     = dcs_en_reg;
      pm_next         = pm_reg;
      twos_next       = twos_reg;
      sync_en_next    = sync_en_reg;
      sync_every_next = sync_every_reg;
      pready_next     = psel_i & ~penable_i;
      prdata_next     = prdata_reg;
      pslverr_next    = 1'b0;
      if (psel_i & ~penable_i)
      begin
         prdata_next  = 32'h0000_0000;
         pslverr_next = 1'b0;
         if (hit(paddr_i, `ACSO_IDX_DIV))
            prdata_next[2:0] = div_m1_reg;
         else if (hit(paddr_i, `ACSO_IDX_DCS))
            prdata_next[`ACSO_DCS_EN_BIT] = dcs_en_reg;
         else if (hit(paddr_i, `ACSO_IDX_PWR))
            prdata_next[1:0] = pm_reg;
         else if (hit(paddr_i, `ACSO_IDX_FMT))
            prdata_next[`ACSO_FMT_TWOS_BIT] = twos_reg;
         else if (hit(paddr_i, `ACSO_IDX_SYNC))
            prdata_next[1:0] = {sync_every_reg, sync_en_reg};
         else if (hit(paddr_i, `ACSO_IDX_STAT))
         begin
            prdata_next[2:0]                  = dv.phase;
            prdata_next[`ACSO_STAT_SEEN_BIT]  = sync_seen_reg;
            prdata_next[`ACSO_STAT_LOCK_BIT]  = dcs_locked_o;
            prdata_next[`ACSO_STAT_PWR_LSB+:2] = pwr_bits;
         end
         else
            pslverr_next = 1'b1;
      end
      if (wr_acc & hit(paddr_i, `ACSO_IDX_DIV))
         div_m1_next = pwdata_i[2:0];
      if (wr_acc & hit(paddr_i, `ACSO_IDX_DCS))
         dcs_en_next = pwdata_i[`ACSO_DCS_EN_BIT];
      if (wr_acc & hit(paddr_i, `ACSO_IDX_PWR))
         pm_next = pwdata_i[1:0];
      if (wr_acc & hit(paddr_i, `ACSO_IDX_FMT))
         twos_next = pwdata_i[`ACSO_FMT_TWOS_BIT];
      if (wr_acc & hit(paddr_i, `ACSO_IDX_SYNC))
      begin
         sync_en_next    = pwdata_i[`ACSO_SYNC_EN_BIT];
         sync_every_next = pwdata_i[`ACSO_SYNC_EVERY_BIT];
      end
      // Sticky flag: a new sync beats a same-cycle clear
      sync_seen_next = (sync_seen_reg & ~(wr_acc & hit(paddr_i, `ACSO_IDX_STAT)
                       & pwdata_i[`ACSO_STAT_SEEN_BIT])) | sync_valid;
      // One-shot mode remembers the first strobe until disarmed
      sync_done_next = sync_en_reg & (sync_done_reg | sync_valid);
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         div_m1_reg     <= `ACSO_RST_DIV_M1;
         dcs_en_reg     <= `ACSO_RST_DCS_EN;
         pm_reg         <= `ACSO_RST_PM;
         twos_reg       <= `ACSO_RST_TWOS;
         sync_en_reg    <= 1'b0;
         sync_every_reg <= 1'b0;
         sync_seen_reg  <= 1'b0;
         sync_done_reg  <= 1'b0;
         pready_reg     <= 1'b0;
         pslverr_reg    <= 1'b0;
         prdata_reg     <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         div_m1_reg     <= div_m1_next;
         dcs_en_reg     <= dcs_en_next;
         pm_reg         <= pm_next;
         twos_reg       <= twos_next;
         sync_en_reg    <= sync_en_next;
         sync_every_reg <= sync_every_next;
         sync_seen_reg  <= sync_seen_next;
         sync_done_reg  <= sync_done_next;
         pready_reg     <= pready_next;
         pslverr_reg    <= pslverr_next;
         prdata_reg     <= prdata_next;
      end
   end

   assign pready_o  = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign prdata_o  = prdata_reg;

   // Pin synchronisers; stage one feeds only stage two
   logic [2:0] pin_sh_reg, pin_sh_next;
   logic [2:0] syn_sh_reg, syn_sh_next;
   logic       pin_lvl_reg, pin_lvl_next;
   logic       syn_lvl_reg, syn_lvl_next;

   always_comb
   begin
      pin_sh_next  = {pin_sh_reg[1:0], power_down_pin_i};
      syn_sh_next  = {syn_sh_reg[1:0], sync_i};
      pin_lvl_next = (pin_sh_reg[1] == pin_sh_reg[2]) ? pin_sh_reg[2]
                                                      : pin_lvl_reg;
      syn_lvl_next = (syn_sh_reg[1] == syn_sh_reg[2]) ? syn_sh_reg[2]
                                                      : syn_lvl_reg;
      // Arm-once unless the every-strobe bit is set
      sync_valid   = syn_lvl_next & ~syn_lvl_reg & sync_en_reg
                     & (sync_every_reg | ~sync_done_reg);
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         pin_sh_reg  <= 3'h0;
         syn_sh_reg  <= 3'h0;
         pin_lvl_reg <= 1'b0;
         syn_lvl_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         pin_sh_reg  <= pin_sh_next;
         syn_sh_reg  <= syn_sh_next;
         pin_lvl_reg <= pin_lvl_next;
         syn_lvl_reg <= syn_lvl_next;
      end
   end

   // Power sequencer; wake time scales with time spent down
   acso_pwr_t         pwr_next;
   logic [DOWN_W-1:0] down_cnt_reg, down_cnt_next;
   logic [DOWN_W-1:0] wake_cnt_reg, wake_cnt_next;
   logic              req_down, req_stby;

   always_comb
   begin
      req_down      = pin_lvl_reg | (pm_reg == `ACSO_PM_DOWN);
      req_stby      = (pm_reg == `ACSO_PM_STANDBY);
      pwr_next      = pwr_reg;
      down_cnt_next = down_cnt_reg;
      wake_cnt_next = wake_cnt_reg;
      case (pwr_reg)
         PWR_RUN:
            if (req_down)
            begin
               pwr_next      = PWR_DOWN;
               down_cnt_next = '0;
            end
            else if (req_stby)
               pwr_next = PWR_STANDBY;
         PWR_DOWN:
         begin
            if (~&down_cnt_reg)
               down_cnt_next = down_cnt_reg + 1'b1;
            if (~req_down & req_stby)
               pwr_next = PWR_STANDBY;
            else if (~req_down)
            begin
               pwr_next      = PWR_WAKE;
               wake_cnt_next = (down_cnt_reg >> `ACSO_WAKE_SHIFT) + 1'b1;
            end
         end
         PWR_STANDBY:
            if (req_down)
            begin
               pwr_next      = PWR_DOWN;
               down_cnt_next = '0;
            end
            else if (~req_stby)
            begin
               pwr_next      = PWR_WAKE;
               wake_cnt_next = DOWN_W'(`ACSO_STBY_WAKE_CYC);
            end
         PWR_WAKE:
            if (req_down)
            begin
               pwr_next      = PWR_DOWN;
               down_cnt_next = '0;
            end
            else if (wake_cnt_reg <= DOWN_W'(1))
               pwr_next = PWR_RUN;
            else
               wake_cnt_next = wake_cnt_reg - 1'b1;
         default:
            pwr_next = PWR_DOWN;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         pwr_reg      <= PWR_RUN;
         down_cnt_reg <= '0;
         wake_cnt_reg <= '0;
         ref_en_o     <= 1'b1;
         bias_en_o    <= 1'b1;
         clk_run_o    <= 1'b1;
         out_oe_n_o   <= 1'b1;
      end
      else if (ce_i)
      begin
         pwr_reg      <= pwr_next;
         down_cnt_reg <= down_cnt_next;
         wake_cnt_reg <= wake_cnt_next;
         ref_en_o     <= (pwr_next != PWR_DOWN);
         bias_en_o    <= (pwr_next == PWR_RUN) | (pwr_next == PWR_WAKE);
         clk_run_o    <= (pwr_next == PWR_RUN) | (pwr_next == PWR_WAKE);
         out_oe_n_o   <= (pwr_next != PWR_RUN);
      end
   end

   // Divider control; clock tree stops in standby and power-down
   assign dv.ce       = ce_i;
   assign dv.run      = clk_run_o;
   assign dv.resync   = sync_valid;
   assign dv.ratio_m1 = div_m1_reg;

   // Stabilizer relock timer, restarted by any rate change
   logic [7:0] relock_reg, relock_next;
   logic       locked_next, int_clk_next;
   logic [3:0] ratio;

   always_comb
   begin
      ratio       = {1'b0, div_m1_reg} + 4'h1;
      relock_next = relock_reg;
      if (~dcs_en_reg | ~clk_run_o | (div_m1_next != div_m1_reg)
          | ~dcs_capable(div_m1_reg))
         relock_next = 8'(`ACSO_DCS_RELOCK_CYC);
      else if (relock_reg != 8'h00)
         relock_next = relock_reg - 8'h01;
      locked_next = dcs_en_reg & clk_run_o & dcs_capable(div_m1_reg)
                    & (relock_reg == 8'h00);
      // Locked: half-period high; bypass: one input cycle high
      if (dcs_locked_o)
         int_clk_next = dv.run & ({dv.phase, 1'b0} < ratio);
      else
         int_clk_next = dv.run & (dv.phase == 3'h0);
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         relock_reg    <= 8'(`ACSO_DCS_RELOCK_CYC);
         dcs_locked_o  <= 1'b0;
         int_clk_o     <= 1'b0;
         sample_tick_o <= 1'b0;
      end
      else if (ce_i)
      begin
         relock_reg    <= relock_next;
         dcs_locked_o  <= locked_next;
         int_clk_o     <= int_clk_next;
         sample_tick_o <= dv.tick;
      end
   end

   // Sample pipeline and double-rate output frame
   acso_word_t pipe_reg [LATENCY-1][4];
   acso_word_t pipe_next [LATENCY-1][4];
   acso_word_t hold_reg [4], hold_next [4];
   acso_word_t bd0_reg, bd1_reg, bd0_next, bd1_next;
   acso_word_t lane0_next, lane1_next;
   acso_ddr_t  ddr_reg, ddr_next;
   logic       dco_next;

   always_comb
   begin
      pipe_next = pipe_reg;
      hold_next = hold_reg;
      if (dv.tick & (pwr_reg == PWR_RUN))
      begin
         for (int c = 0; c < 4; c++)
         begin
            pipe_next[0][c] = clamp_ob(core_i[18*c +: 18]);
            for (int s = 1; s < LATENCY - 1; s++)
               pipe_next[s][c] = pipe_reg[s-1][c];
            hold_next[c] = pipe_reg[LATENCY-2][c];
         end
      end
      // Frame: A,C before the rise, B,D before the fall
      ddr_next   = acso_ddr_t'(ddr_reg + 2'h1);
      lane0_next = dlane0_o;
      lane1_next = dlane1_o;
      bd0_next   = bd0_reg;
      bd1_next   = bd1_reg;
      dco_next   = data_clock_out_o;
      case (ddr_reg)
         DDR_AC:
         begin
            lane0_next = fmt(hold_reg[0], twos_reg);
            lane1_next = fmt(hold_reg[2], twos_reg);
            bd0_next   = fmt(hold_reg[1], twos_reg);
            bd1_next   = fmt(hold_reg[3], twos_reg);
            dco_next   = 1'b0;
         end
         DDR_RISE: dco_next = 1'b1;
         DDR_BD:
         begin
            lane0_next = bd0_reg;
            lane1_next = bd1_reg;
         end
         DDR_FALL: dco_next = 1'b0;
         default:  ddr_next = DDR_AC;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         pipe_reg         <= '{default: '{default: 16'h0000}};
         hold_reg         <= '{default: 16'h0000};
         bd0_reg          <= 16'h0000;
         bd1_reg          <= 16'h0000;
         ddr_reg          <= DDR_AC;
         dlane0_o         <= 16'h0000;
         dlane1_o         <= 16'h0000;
         data_clock_out_o <= 1'b0;
      end
      else if (ce_i)
      begin
         pipe_reg         <= pipe_next;
         hold_reg         <= hold_next;
         bd0_reg          <= bd0_next;
         bd1_reg          <= bd1_next;
         ddr_reg          <= ddr_next;
         dlane0_o         <= lane0_next;
         dlane1_o         <= lane1_next;
         data_clock_out_o <= dco_next;
      end
   end

endmodule

`default_nettype wire

// ### tb/acso_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks beside the top module
module acso_top_chk
#(
   parameter int CLK_HZ = 10000000  // Input clock rate
)
(
   input wire logic        clock_i,           // Clock
   input wire logic        sys_rst_i,         // Reset
   input wire logic        ce_i,              // Enable
   input wire logic        psel_i,            // Select
   input wire logic        penable_i,         // Access
   input wire logic        pwrite_i,          // Write
   input wire logic [31:0] prdata_o,          // Read data
   input wire logic        pready_o,          // Ready
   input wire logic        pslverr_o,         // Error
   input wire logic        power_down_pin_i,  // Pin
   input wire logic [15:0] dlane0_o,          // Lane 0
   input wire logic [15:0] dlane1_o,          // Lane 1
   input wire logic        data_clock_out_o,  // Data clock
   input wire logic        out_oe_n_o,        // Lanes off
   input wire logic        ref_en_o,          // Reference
   input wire logic        clk_run_o,         // Clock tree
   input wire logic        dcs_locked_o       // Lock
);
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   a_ready_setup: assert property (psel_i && !penable_i && ce_i |=> pready_o)
      else $error("ready missing after setup");
   a_ready_pulse: assert property (pready_o && ce_i |=> !pready_o)
      else $error("ready held too long");
   a_err_ready: assert property (pslverr_o |-> pready_o && penable_i)
      else $error("error outside access");
   a_err_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("refused read not zero");
   // Sync stages plus state update fit inside six cycles
   a_pin_off: assert property (power_down_pin_i [*6] |->
      out_oe_n_o && !ref_en_o && !clk_run_o)
      else $error("pin did not power down");
   a_dco_frame: assert property ($rose(data_clock_out_o) ##1
      clk_run_o [*2] |-> $fell(data_clock_out_o))
      else $error("data clock high time wrong");
   a_lane_steady: assert property ($changed(data_clock_out_o) |->
      $stable(dlane0_o) && $stable(dlane1_o))
      else $error("lanes move on data clock edge");
   a_no_lock_slow: assert property (CLK_HZ < 40000000 |-> !dcs_locked_o)
      else $error("lock below minimum rate");

   c_err: cover property (pslverr_o);
   c_down: cover property ($rose(out_oe_n_o));
   c_frame: cover property ($rose(data_clock_out_o));
endmodule

bind acso_top acso_top_chk #(.CLK_HZ(CLK_HZ)) u_chk (.clock_i, .sys_rst_i,
   .ce_i, .psel_i, .penable_i, .pwrite_i, .prdata_o, .pready_o, .pslverr_o,
   .power_down_pin_i, .dlane0_o, .dlane1_o, .data_clock_out_o, .out_oe_n_o,
   .ref_en_o, .clk_run_o, .dcs_locked_o);

`default_nettype wire

// ### tb/acso_ddr_rx.sv
`timescale 1ns/1ps
`default_nettype none

// Receiving logic capturing both lanes on both data clock edges
module acso_ddr_rx
   import acso_pkg::*;
(
   input  wire logic        dco_i,    // Data clock
   input  wire logic [15:0] lane0_i,  // A then B
   input  wire logic [15:0] lane1_i,  // C then D
   output var acso_word_t   a_o,      // Channel A
   output var acso_word_t   b_o,      // Channel B
   output var acso_word_t   c_o,      // Channel C
   output var acso_word_t   d_o       // Channel D
);
   // Rising edge holds the first pair
   always @(posedge dco_i)
   begin
      a_o <= lane0_i;
      c_o <= lane1_i;
   end

   // Falling edge holds the second pair
   always @(negedge dco_i)
   begin
      b_o <= lane0_i;
      d_o <= lane1_i;
   end
endmodule

`default_nettype wire

// ### tb/adc_clock_sync_output_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acso_regs.svh"

module adc_clock_sync_output_ctrl_tb_top;
   logic        clock_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h0;
   logic [31:0] pwdata_i = 32'h0;
   logic        power_down_pin_i = 1'b0;
   logic        sync_i = 1'b0;
   logic [71:0] core_i = 72'h0;
   logic [31:0] prdata_o;
   logic [15:0] dlane0_o, dlane1_o, cap_a, cap_b, cap_c, cap_d;
   logic        pready_o, pslverr_o, data_clock_out_o, out_oe_n_o, int_clk_o;
   logic        sample_tick_o, ref_en_o, bias_en_o, clk_run_o, dcs_locked_o;
   int          n_errors = 0;
   int          n_compared = 0;

   // Clock of 100 ns
   always #50 clock_i = ~clock_i;

   acso_top DUT (.clock_i, .sys_rst_i, .ce_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .power_down_pin_i, .sync_i, .core_i, .dlane0_o, .dlane1_o,
      .data_clock_out_o, .out_oe_n_o, .int_clk_o, .sample_tick_o,
      .ref_en_o, .bias_en_o, .clk_run_o, .dcs_locked_o);

   acso_ddr_rx u_rx (.dco_i(data_clock_out_o), .lane0_i(dlane0_o),
      .lane1_i(dlane1_o), .a_o(cap_a), .b_o(cap_b), .c_o(cap_c), .d_o(cap_d));

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Bus cycle: setup, then access held until ready is sampled
   task automatic apb(input logic w, input logic [7:0] idx,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int k;
      k = 0;
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= {2'h0, idx, 2'h0};
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge clock_i);
         k++;
      end
      while (pready_o !== 1'b1 && k < 16);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (k >= 16)
      begin
         n_errors++;
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] r);
      logic e;
      apb(1'b0, idx, 32'h0, r, e);
   endtask

   // Bounded waits; running out counts as a mismatch
   task automatic wait_tick(output int n);
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (sample_tick_o !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         n_errors++;
         complete_run();
      end
   endtask

   task automatic wait_on();
      int k;
      k = 0;
      while (out_oe_n_o !== 1'b0 && k < 400)
      begin
         @(posedge clock_i);
         k++;
      end
      chk("lanes back on", 32'h0, {31'h0, out_oe_n_o});
   endtask

   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      rd(`ACSO_IDX_DIV, r);
      chk("divider reset", 32'h0, r);
      rd(`ACSO_IDX_DCS, r);
      chk("stabilizer reset", 32'h1, r);
      rd(`ACSO_IDX_STAT, r);
      chk("status reset", 32'h0, r & 32'h78);
      apb(1'b0, 8'hff, 32'h0, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
      $display("test regs done");
   endtask

   task automatic t_ratio();
      int n;
      for (int q = 1; q <= 8; q++)
      begin
         wr(`ACSO_IDX_DIV, 32'(q - 1));
         repeat (3) wait_tick(n);
         chk("tick spacing", 32'(q), 32'(n));
         chk("int clock", 32'h1, {31'h0, int_clk_o});
      end
      repeat (`ACSO_DCS_RELOCK_CYC) @(posedge clock_i);
      chk("no lock", 32'h0, {31'h0, dcs_locked_o});
      $display("test ratio done");
   endtask

   // Strobe phase differs each pass; tick must follow the strobe
   task automatic t_sync();
      logic [31:0] r;
      int          n;
      wr(`ACSO_IDX_SYNC, 32'h3);
      for (int i = 0; i < 2; i++)
      begin
         wr(`ACSO_IDX_DIV, 32'h7);
         repeat (i * 3) @(posedge clock_i);
         sync_i <= 1'b1;
         repeat (5) @(posedge clock_i);
         wait_tick(n);
         chk("sync align", 32'h1, {31'h0, n <= 2});
         sync_i <= 1'b0;
         repeat (4) @(posedge clock_i);
         rd(`ACSO_IDX_STAT, r);
         chk("sync seen", 32'h8, r & 32'h8);
         wr(`ACSO_IDX_STAT, 32'h8);
         rd(`ACSO_IDX_STAT, r);
         chk("sync cleared", 32'h0, r & 32'h8);
      end
      wr(`ACSO_IDX_SYNC, 32'h1);
      sync_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      rd(`ACSO_IDX_STAT, r);
      chk("one shot", 32'h0, r & 32'h8);
      $display("test sync done");
   endtask

   task automatic t_coding();
      logic [15:0] m;
      wr(`ACSO_IDX_DIV, 32'h0);
      core_i <= {18'h00064, 18'h1ffff, 18'h00000, 18'h20000};
      for (int f = 0; f < 2; f++)
      begin
         m = f ? 16'h8000 : 16'h0000;
         wr(`ACSO_IDX_FMT, 32'(f));
         repeat (40) @(posedge clock_i);
         chk("chan a", {16'h0, m}, {16'h0, cap_a});
         chk("chan b", {16'h0, 16'h8000 ^ m}, {16'h0, cap_b});
         chk("chan c", {16'h0, 16'hffff ^ m}, {16'h0, cap_c});
         chk("chan d", {16'h0, 16'h8064 ^ m}, {16'h0, cap_d});
      end
      wr(`ACSO_IDX_FMT, 32'h0);
      repeat (20) @(posedge clock_i);
      core_i[17:0] <= 18'h00064;
      repeat (7) @(posedge clock_i);
      chk("latency old", 32'h0, {16'h0, cap_a});
      repeat (30) @(posedge clock_i);
      chk("latency new", 32'h8064, {16'h0, cap_a});
      $display("test coding done");
   endtask

   task automatic t_power();
      logic [31:0] r;
      power_down_pin_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      chk("pin off", 32'h1, {31'h0, out_oe_n_o});
      chk("pin stops", 32'h0, {29'h0, ref_en_o, bias_en_o, clk_run_o});
      rd(`ACSO_IDX_STAT, r);
      chk("state down", 32'h2, {30'h0, r[6:5]});
      power_down_pin_i <= 1'b0;
      wait_on();
      chk("pin ref on", 32'h1, {31'h0, ref_en_o});
      wr(`ACSO_IDX_PWR, 32'h1);
      repeat (4) @(posedge clock_i);
      chk("reg off", 32'h1, {31'h0, out_oe_n_o});
      chk("reg ref off", 32'h0, {31'h0, ref_en_o});
      wr(`ACSO_IDX_PWR, 32'h2);
      repeat (15) @(posedge clock_i);
      chk("standby", 32'h3, {30'h0, out_oe_n_o, ref_en_o});
      wr(`ACSO_IDX_PWR, 32'h0);
      wait_on();
      $display("test power done");
   endtask

   initial
   begin
      repeat (4) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      t_regs();
      t_ratio();
      t_sync();
      t_coding();
      t_power();
      complete_run();
   end
endmodule

`default_nettype wire
